// ===== inc/fspc_params.svh
`ifndef FSPC_PARAMS_SVH
`define FSPC_PARAMS_SVH
// Register offsets
`define FSPC_OFF_DATA_LOW 3'h0
`define FSPC_OFF_DATA_HIGH 3'h1
`define FSPC_OFF_ADDR_LOW 3'h2
`define FSPC_OFF_ADDR_HIGH 3'h3
`define FSPC_OFF_CONTROL 3'h4
`define FSPC_OFF_UNLOCK_KEY 3'h5
// Control field positions
`define FSPC_BIT_CONFIG_SPACE_SELECT 6
`define FSPC_BIT_LATCH_LOAD_ONLY 5
`define FSPC_BIT_ERASE 4
`define FSPC_BIT_ERR 3
`define FSPC_BIT_PROGRAM_ENABLE 2
`define FSPC_BIT_WR 1
`define FSPC_BIT_RD 0
// Reset and fixed values
`define FSPC_RST_BYTE 8'h00
`define FSPC_RST_ADDR 15'h0000
`define FSPC_RST_WORD 14'h0000
`define FSPC_BLANK_WORD 14'h3FFF
`define FSPC_PAD_ONE 1'h1
`define FSPC_PAD_ZERO 2'h0
// Unlock pattern
`define FSPC_KEY_FIRST 8'h55
`define FSPC_KEY_SECOND 8'hAA
// Configuration space, offsets below the 8000h base
`define FSPC_UID_FIRST 15'h0000
`define FSPC_UID_LAST 15'h0003
`define FSPC_REV_ADDR 15'h0005
`define FSPC_DEV_ADDR 15'h0006
`define FSPC_CW1_ADDR 15'h0007
`define FSPC_CW2_ADDR 15'h0008
// Read fetch latency in cycles
`define FSPC_READ_CYCLES 1
`endif

// ===== inc/fspc_pkg.sv
`default_nettype none
package fspc_pkg;
  typedef enum logic [2:0] {
    FSPC_ST_IDLE = 3'b001,
    FSPC_ST_PROG = 3'b010,
    FSPC_ST_ERASE = 3'b100
  } fspc_state_e;
  typedef enum logic [2:0] {
    FSPC_KEY_NONE = 3'b001,
    FSPC_KEY_HALF = 3'b010,
    FSPC_KEY_ARMED = 3'b100
  } fspc_key_e;
  typedef struct packed {
    logic config_space_select;
    logic latch_load_only;
    logic erase_sel;
    logic err;
    logic program_enable;
    logic wr;
    logic rd;
  } fspc_ctrl_s;
  typedef struct packed {
    fspc_state_e fsm;
    fspc_key_e key;
    fspc_ctrl_s ctrl;
    logic op_cfg;
    logic [7:0] data_lo;
    logic [5:0] data_hi;
    logic [14:0] addr;
    logic [7:0] rdata;
    logic [3:0][13:0] uid;
    logic prog_pulse;
    logic erase_pulse;
  } fspc_top_s;
endpackage
`default_nettype wire

// ===== logic/fspc_latch_row.sv
`default_nettype none
`include "fspc_params.svh"
module fspc_latch_row #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 14,
  parameter logic [WIDTH-1:0] BLANK = `FSPC_BLANK_WORD
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Load and blank
  input wire logic load_i,
  input wire logic [$clog2(DEPTH)-1:0] idx_i,
  input wire logic [WIDTH-1:0] word_i,
  input wire logic blank_i,
  // Row image
  output logic [DEPTH-1:0][WIDTH-1:0] row_o
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] words;
  } fspc_latch_s;
  fspc_latch_s latch_ff;
  fspc_latch_s nxt_latch;

  always_comb
  begin
    nxt_latch = latch_ff;
    if (blank_i)
    begin
      nxt_latch.words = {DEPTH{BLANK}};
    end
    else if (load_i)
    begin
      nxt_latch.words[idx_i] = word_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latch_ff <= {DEPTH{BLANK}};
    end
    else
    begin
      latch_ff <= nxt_latch;
    end
  end

  assign row_o = latch_ff.words;
endmodule
`default_nettype wire

// ===== logic/fspc_top.sv
`default_nettype none
`include "fspc_params.svh"
module fspc_top
  import fspc_pkg::*;
#(
  parameter int LATCHES = 32,
  parameter logic [13:0] REV_ID = 14'h0001,
  parameter logic [13:0] DEV_ID = 14'h0002
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Register port
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // Flash array
  output logic FLASH_RD_EN_O,
  output logic [14:0] FLASH_ADDR_O,
  input wire logic [13:0] FLASH_RD_DATA_I,
  output logic FLASH_PROG_O,
  output logic FLASH_ERASE_O,
  output logic [LATCHES-1:0][13:0] FLASH_ROW_DATA_O,
  input wire logic FLASH_DONE_I,
  // Configuration fuses
  input wire logic [13:0] CFG_WORD1_I,
  input wire logic [13:0] CFG_WORD2_I,
  // Status
  output logic BUSY_O
);
  localparam int IDX_W = $clog2(LATCHES);

  fspc_top_s st_ff;
  fspc_top_s nxt_st;
  logic latch_load;
  logic latch_blank;
  logic start_op;
  logic op_done;
  logic uid_hit;
  logic cfg_readable;
  logic [13:0] fetch_word;
  logic [13:0] cfg_word;
  logic [LATCHES-1:0][13:0] row;

  // Configuration space decode
  always_comb
  begin
    uid_hit = (st_ff.addr >= `FSPC_UID_FIRST) && (st_ff.addr <= `FSPC_UID_LAST);
    cfg_readable = 1'b1;
    cfg_word = `FSPC_RST_WORD;
    if (uid_hit)
    begin
      cfg_word = st_ff.uid[st_ff.addr[1:0]];
    end
    else
    begin
      case (st_ff.addr)
        `FSPC_REV_ADDR: cfg_word = REV_ID;
        `FSPC_DEV_ADDR: cfg_word = DEV_ID;
        `FSPC_CW1_ADDR: cfg_word = CFG_WORD1_I;
        `FSPC_CW2_ADDR: cfg_word = CFG_WORD2_I;
        default: cfg_readable = 1'b0;
      endcase
    end
    fetch_word = st_ff.ctrl.config_space_select ? (cfg_readable ? cfg_word : `FSPC_RST_WORD) : FLASH_RD_DATA_I;
  end

  assign op_done = st_ff.op_cfg | FLASH_DONE_I;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.prog_pulse = 1'b0;
    nxt_st.erase_pulse = 1'b0;
    nxt_st.rdata = `FSPC_RST_BYTE;
    latch_load = 1'b0;
    latch_blank = 1'b0;
    start_op = 1'b0;
    // Hardware side of the control register
    case (st_ff.fsm)
      FSPC_ST_IDLE:
      begin
        if (st_ff.ctrl.rd)
        begin
          nxt_st.data_lo = fetch_word[7:0];
          nxt_st.data_hi = fetch_word[13:8];
          nxt_st.ctrl.rd = 1'b0;
        end
        if (st_ff.ctrl.wr)
        begin
          nxt_st.ctrl.wr = 1'b0;
          nxt_st.ctrl.err = 1'b0;
        end
      end
      FSPC_ST_PROG:
      begin
        if (op_done)
        begin
          if (st_ff.op_cfg && uid_hit)
          begin
            for (int i = 0; i < 4; i++)
            begin
              nxt_st.uid[i] = st_ff.uid[i] & row[i];
            end
          end
          latch_blank = 1'b1;
          nxt_st.ctrl.wr = 1'b0;
          nxt_st.ctrl.err = 1'b0;
          nxt_st.fsm = FSPC_ST_IDLE;
        end
      end
      FSPC_ST_ERASE:
      begin
        if (op_done)
        begin
          if (st_ff.op_cfg && uid_hit)
          begin
            nxt_st.uid = {4{`FSPC_BLANK_WORD}};
          end
          latch_blank = 1'b1;
          nxt_st.ctrl.wr = 1'b0;
          nxt_st.ctrl.err = 1'b0;
          nxt_st.ctrl.erase_sel = 1'b0;
          nxt_st.fsm = FSPC_ST_IDLE;
        end
      end
      default:
      begin
        nxt_st.fsm = FSPC_ST_IDLE;
      end
    endcase
    // Register reads
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        `FSPC_OFF_DATA_LOW: nxt_st.rdata = st_ff.data_lo;
        `FSPC_OFF_DATA_HIGH: nxt_st.rdata = {`FSPC_PAD_ZERO, st_ff.data_hi};
        `FSPC_OFF_ADDR_LOW: nxt_st.rdata = st_ff.addr[7:0];
        `FSPC_OFF_ADDR_HIGH: nxt_st.rdata = {`FSPC_PAD_ONE, st_ff.addr[14:8]};
        `FSPC_OFF_CONTROL: nxt_st.rdata = {`FSPC_PAD_ONE, st_ff.ctrl};
        default: nxt_st.rdata = `FSPC_RST_BYTE;
      endcase
    end
    // Register writes; any write other than the key pattern disarms the unlock
    if (REG_WR_I)
    begin
      nxt_st.key = FSPC_KEY_NONE;
      case (REG_ADDR_I)
        `FSPC_OFF_DATA_LOW: nxt_st.data_lo = REG_WDATA_I;
        `FSPC_OFF_DATA_HIGH: nxt_st.data_hi = REG_WDATA_I[5:0];
        `FSPC_OFF_ADDR_LOW: nxt_st.addr[7:0] = REG_WDATA_I;
        `FSPC_OFF_ADDR_HIGH: nxt_st.addr[14:8] = REG_WDATA_I[6:0];
        `FSPC_OFF_UNLOCK_KEY:
        begin
          if (REG_WDATA_I == `FSPC_KEY_FIRST)
          begin
            nxt_st.key = FSPC_KEY_HALF;
          end
          else if (REG_WDATA_I == `FSPC_KEY_SECOND && st_ff.key == FSPC_KEY_HALF)
          begin
            nxt_st.key = FSPC_KEY_ARMED;
          end
        end
        `FSPC_OFF_CONTROL:
        begin
          nxt_st.ctrl.config_space_select = REG_WDATA_I[`FSPC_BIT_CONFIG_SPACE_SELECT];
          nxt_st.ctrl.latch_load_only = REG_WDATA_I[`FSPC_BIT_LATCH_LOAD_ONLY];
          nxt_st.ctrl.erase_sel = REG_WDATA_I[`FSPC_BIT_ERASE];
          nxt_st.ctrl.program_enable = REG_WDATA_I[`FSPC_BIT_PROGRAM_ENABLE];
          nxt_st.ctrl.err = REG_WDATA_I[`FSPC_BIT_ERR] | REG_WDATA_I[`FSPC_BIT_WR];
          if (REG_WDATA_I[`FSPC_BIT_RD] && st_ff.fsm == FSPC_ST_IDLE)
          begin
            nxt_st.ctrl.rd = 1'b1;
          end
          // Enable is taken from the same write, so one control write may enable and start
          if (REG_WDATA_I[`FSPC_BIT_WR] && !REG_WDATA_I[`FSPC_BIT_RD] && st_ff.key == FSPC_KEY_ARMED
              && REG_WDATA_I[`FSPC_BIT_PROGRAM_ENABLE] && !st_ff.ctrl.wr && !st_ff.ctrl.rd
              && st_ff.fsm == FSPC_ST_IDLE)
          begin
            start_op = 1'b1;
            nxt_st.ctrl.wr = 1'b1;
            nxt_st.op_cfg = st_ff.ctrl.config_space_select;
            if (REG_WDATA_I[`FSPC_BIT_ERASE])
            begin
              nxt_st.fsm = FSPC_ST_ERASE;
              nxt_st.erase_pulse = !st_ff.ctrl.config_space_select;
            end
            else
            begin
              latch_load = !st_ff.ctrl.config_space_select || uid_hit;
              if (!REG_WDATA_I[`FSPC_BIT_LATCH_LOAD_ONLY])
              begin
                nxt_st.fsm = FSPC_ST_PROG;
                nxt_st.prog_pulse = !st_ff.ctrl.config_space_select;
              end
            end
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      st_ff <= '{fsm: FSPC_ST_IDLE, key: FSPC_KEY_NONE, ctrl: '0, op_cfg: 1'b0,
                 data_lo: `FSPC_RST_BYTE, data_hi: 6'h00, addr: `FSPC_RST_ADDR, rdata: `FSPC_RST_BYTE,
                 uid: {4{`FSPC_BLANK_WORD}}, prog_pulse: 1'b0, erase_pulse: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  fspc_latch_row #(
    .DEPTH(LATCHES),
    .WIDTH(14),
    .BLANK(`FSPC_BLANK_WORD)
  ) u_latch (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(latch_load),
    .idx_i(st_ff.addr[IDX_W-1:0]),
    .word_i({st_ff.data_hi, st_ff.data_lo}),
    .blank_i(latch_blank),
    .row_o(row)
  );

  assign REG_RDATA_O = st_ff.rdata;
  assign FLASH_RD_EN_O = st_ff.ctrl.rd && !st_ff.ctrl.config_space_select;
  assign FLASH_ADDR_O = st_ff.addr;
  assign FLASH_PROG_O = st_ff.prog_pulse;
  assign FLASH_ERASE_O = st_ff.erase_pulse;
  assign FLASH_ROW_DATA_O = row;
  assign BUSY_O = st_ff.ctrl.wr;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic key_armed;
  logic ctrl_wr_cyc;
  assign key_armed = st_ff.key == FSPC_KEY_ARMED;
  assign ctrl_wr_cyc = REG_WR_I && REG_ADDR_I == `FSPC_OFF_CONTROL;

  a_cfg_bad_read: assert property (st_ff.ctrl.rd && st_ff.ctrl.config_space_select && !cfg_readable && !REG_WR_I
    |=> st_ff.data_lo == 8'h00 && st_ff.data_hi == 6'h00) else $error("bad config read not zero");
  a_data_high_pad: assert property (REG_RD_I && REG_ADDR_I == `FSPC_OFF_DATA_HIGH
    |=> REG_RDATA_O[7:6] == 2'h0) else $error("data high pad not zero");
  a_addr_high_one: assert property (REG_RD_I && REG_ADDR_I == `FSPC_OFF_ADDR_HIGH
    |=> REG_RDATA_O[7] && REG_RDATA_O[6:0] == $past(st_ff.addr[14:8])) else $error("address high wrong");
  a_latch_load_only_no_prog: assert property (start_op && REG_WDATA_I[`FSPC_BIT_LATCH_LOAD_ONLY] && !REG_WDATA_I[`FSPC_BIT_ERASE]
    |=> !FLASH_PROG_O
    ##1 !BUSY_O) else $error("latch load started programming");
  a_prog_start: assert property (start_op && !REG_WDATA_I[`FSPC_BIT_LATCH_LOAD_ONLY] && !REG_WDATA_I[`FSPC_BIT_ERASE]
    && !st_ff.ctrl.config_space_select |=> FLASH_PROG_O && BUSY_O) else $error("program not started");
  a_erase_clears: assert property (st_ff.fsm == FSPC_ST_ERASE && op_done && !ctrl_wr_cyc
    |=> !st_ff.ctrl.erase_sel && !BUSY_O) else $error("erase select not cleared");
  a_err_attempt: assert property (ctrl_wr_cyc && REG_WDATA_I[`FSPC_BIT_WR]
    |=> st_ff.ctrl.err) else $error("error flag not set");
  a_no_enable: assert property (ctrl_wr_cyc && !REG_WDATA_I[`FSPC_BIT_PROGRAM_ENABLE] |=> !FLASH_PROG_O && !FLASH_ERASE_O)
    else $error("program without enable");
  a_needs_key: assert property (FLASH_PROG_O || FLASH_ERASE_O |-> $past(key_armed))
    else $error("operation without unlock");
  a_rd_one_cycle: assert property (st_ff.ctrl.rd |=> !st_ff.ctrl.rd) else $error("read strobe stuck");
  a_key_hidden: assert property (REG_RD_I && REG_ADDR_I == `FSPC_OFF_UNLOCK_KEY
    |=> REG_RDATA_O == 8'h00) else $error("unlock key readable");
  a_latch_blank: assert property (st_ff.fsm != FSPC_ST_IDLE && op_done
    |=> row == {LATCHES{`FSPC_BLANK_WORD}}) else $error("latches not blank");

  c_prog: cover property (FLASH_PROG_O ##[1:50] !BUSY_O);
  c_erase: cover property (FLASH_ERASE_O ##[1:50] !BUSY_O);
  c_cfg_read: cover property (st_ff.ctrl.rd && st_ff.ctrl.config_space_select);
  c_latch_only: cover property (start_op && REG_WDATA_I[`FSPC_BIT_LATCH_LOAD_ONLY]);
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} fspc_case_s;
  logic CLK_I;
  logic SYS_RST_I;
  logic [2:0] REG_ADDR_I;
  logic [7:0] REG_WDATA_I;
  logic REG_WR_I;
  logic REG_RD_I;
  logic [7:0] REG_RDATA_O;
  logic FLASH_RD_EN_O;
  logic [14:0] FLASH_ADDR_O;
  logic [13:0] FLASH_RD_DATA_I;
  logic FLASH_PROG_O;
  logic FLASH_ERASE_O;
  logic [31:0][13:0] FLASH_ROW_DATA_O;
  logic FLASH_DONE_I;
  logic [13:0] CFG_WORD1_I;
  logic [13:0] CFG_WORD2_I;
  logic BUSY_O;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int prog_cnt = 0;
  int erase_cnt = 0;
  fspc_case_s cases [7] = '{'{3'h0, 8'hFF, 8'hFF}, '{3'h1, 8'hFF, 8'h3F}, '{3'h2, 8'hA5, 8'hA5},
    '{3'h3, 8'h7F, 8'hFF}, '{3'h3, 8'h00, 8'h80}, '{3'h5, 8'h55, 8'h00}, '{3'h6, 8'h12, 8'h00}};

  fspc_top u_dut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .FLASH_RD_EN_O(FLASH_RD_EN_O),
    .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_RD_DATA_I(FLASH_RD_DATA_I), .FLASH_PROG_O(FLASH_PROG_O),
    .FLASH_ERASE_O(FLASH_ERASE_O), .FLASH_ROW_DATA_O(FLASH_ROW_DATA_O), .FLASH_DONE_I(FLASH_DONE_I),
    .CFG_WORD1_I(CFG_WORD1_I), .CFG_WORD2_I(CFG_WORD2_I), .BUSY_O(BUSY_O));

  initial
  begin
    CLK_I = 1'b0;
    forever #2.5 CLK_I = ~CLK_I;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Flash pulse counters and hang guard; falling edge keeps them clear of the stimulus edge
  always @(negedge CLK_I)
  begin
    cyc++;
    if (FLASH_PROG_O === 1'b1)
      prog_cnt++;
    if (FLASH_ERASE_O === 1'b1)
      erase_cnt++;
    if (cyc == 3000)
    begin
      bad_count++;
      $display("BAD t=%0t run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD t=%0t seen %h want %h", $time, s, e);
    end
  endtask

  // One write cycle, then one idle cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge CLK_I);
    REG_WR_I <= 1'b0;
    @(posedge CLK_I);
  endtask

  // Read cycle; data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge CLK_I);
    REG_RD_I <= 1'b0;
    #1;
    chk(16'(REG_RDATA_O), 16'(e));
    @(posedge CLK_I);
  endtask

  task automatic unlock(input logic [7:0] c);
    wr(3'h5, 8'h55);
    wr(3'h5, 8'hAA);
    wr(3'h4, c);
  endtask

  task automatic done_pulse();
    FLASH_DONE_I <= 1'b1;
    @(posedge CLK_I);
    FLASH_DONE_I <= 1'b0;
    @(posedge CLK_I);
  endtask

  initial
  begin
    SYS_RST_I = 1'b1;
    REG_ADDR_I = 3'h0;
    REG_WDATA_I = 8'h00;
    REG_WR_I = 1'b0;
    REG_RD_I = 1'b0;
    FLASH_RD_DATA_I = 14'h2ABC;
    FLASH_DONE_I = 1'b0;
    CFG_WORD1_I = 14'h1C3A;
    CFG_WORD2_I = 14'h0F0F;
    repeat (20) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    @(posedge CLK_I);
    rd(3'h4, 8'h80);
    rd(3'h3, 8'h80);
    chk(16'(FLASH_ROW_DATA_O === {32{14'h3FFF}}), 16'h0001);
    foreach (cases[i])
    begin
      wr(cases[i].a, cases[i].d);
      rd(cases[i].a, cases[i].e);
    end
    // Program array read
    wr(3'h2, 8'h34);
    wr(3'h3, 8'h12);
    chk(16'(FLASH_ADDR_O), 16'h1234);
    wr(3'h4, 8'h01);
    chk(16'(FLASH_RD_EN_O), 16'h0001);
    rd(3'h0, 8'hBC);
    rd(3'h1, 8'h2A);
    rd(3'h4, 8'h80);
    // Latch load only
    wr(3'h2, 8'h25);
    wr(3'h0, 8'h57);
    wr(3'h1, 8'h13);
    unlock(8'h26);
    chk(16'(FLASH_ROW_DATA_O[5]), 16'h1357);
    chk(16'(prog_cnt), 16'h0000);
    rd(3'h4, 8'hA4);
    // Full row program
    wr(3'h2, 8'h26);
    wr(3'h0, 8'h11);
    wr(3'h1, 8'h01);
    unlock(8'h06);
    chk(16'(BUSY_O), 16'h0001);
    chk(16'(prog_cnt), 16'h0001);
    chk(16'(FLASH_ROW_DATA_O[6]), 16'h0111);
    chk(16'(FLASH_ROW_DATA_O[5]), 16'h1357);
    rd(3'h4, 8'h8E);
    wr(3'h4, 8'h04);
    chk(16'(BUSY_O), 16'h0001);
    done_pulse();
    chk(16'(BUSY_O), 16'h0000);
    chk(16'(FLASH_ROW_DATA_O === {32{14'h3FFF}}), 16'h0001);
    rd(3'h4, 8'h84);
    // Broken unlock sequence
    wr(3'h5, 8'h55);
    wr(3'h0, 8'h00);
    wr(3'h5, 8'hAA);
    wr(3'h4, 8'h06);
    chk(16'(BUSY_O), 16'h0000);
    rd(3'h4, 8'h8C);
    // Program enable clear
    unlock(8'h02);
    chk(16'(BUSY_O), 16'h0000);
    chk(16'(prog_cnt), 16'h0001);
    rd(3'h4, 8'h88);
    // Erase with latch-only set
    unlock(8'h36);
    chk(16'(erase_cnt), 16'h0001);
    chk(16'(prog_cnt), 16'h0001);
    done_pulse();
    rd(3'h4, 8'hA4);
    chk(16'(FLASH_ROW_DATA_O === {32{14'h3FFF}}), 16'h0001);
    // Configuration space reads
    wr(3'h3, 8'h00);
    wr(3'h2, 8'h07);
    wr(3'h4, 8'h41);
    rd(3'h0, 8'h3A);
    rd(3'h1, 8'h1C);
    wr(3'h2, 8'h04);
    wr(3'h4, 8'h41);
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    wr(3'h2, 8'h05);
    wr(3'h4, 8'h41);
    rd(3'h0, 8'h01);
    // User ID write and readback
    wr(3'h2, 8'h01);
    wr(3'h0, 8'hAA);
    wr(3'h1, 8'h0A);
    unlock(8'h66);
    unlock(8'h46);
    chk(16'(prog_cnt + erase_cnt), 16'h0002);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    unlock(8'h66);
    wr(3'h2, 8'h05);
    unlock(8'h46);
    wr(3'h2, 8'h01);
    wr(3'h4, 8'h41);
    rd(3'h0, 8'hAA);
    rd(3'h1, 8'h0A);
    tally_and_finish();
  end
endmodule
`default_nettype wire
